// >>> rtl/disp_cmd_pkg.sv
package disp_cmd_pkg;

    // ========================================================
    // Command codes on the packet serial link (one byte)
    localparam logic [7:0] CODE_DIAG_RD   = 8'h0F;
    localparam logic [7:0] CODE_SLEEP_IN  = 8'h10;
    localparam logic [7:0] CODE_SLEEP_OUT = 8'h11;
    localparam logic [7:0] CODE_PARTIAL   = 8'h12;
    localparam logic [7:0] CODE_NORMAL    = 8'h13;
    localparam logic [7:0] CODE_INV_OFF   = 8'h20;
    localparam logic [7:0] CODE_INV_ON    = 8'h21;
    localparam logic [7:0] CODE_ALL_DARK  = 8'h22;
    // Low byte that a 16-bit command address must carry
    localparam logic [7:0] CODE_WIDE_LOW  = 8'h00;

    // ========================================================
    // Decoded operations
    typedef enum logic [3:0] {
        OP_NONE      = 4'b0000,
        OP_DIAG_RD   = 4'b0001,
        OP_SLEEP_IN  = 4'b0010,
        OP_SLEEP_OUT = 4'b0011,
        OP_PARTIAL   = 4'b0100,
        OP_NORMAL    = 4'b0101,
        OP_INV_OFF   = 4'b0110,
        OP_INV_ON    = 4'b0111,
        OP_ALL_DARK  = 4'b1000,
        OP_OTHER     = 4'b1001
    } cmd_op_t;

    // ========================================================
    // Register indices on the plain register port
    localparam logic [3:0] REG_MODE      = 4'h0;
    localparam logic [3:0] REG_DIAG      = 4'h1;
    localparam logic [3:0] REG_EXPECT    = 4'h2;
    localparam logic [3:0] REG_IRQ_STAT  = 4'h3;
    localparam logic [3:0] REG_IRQ_MASK  = 4'h4;
    localparam logic [3:0] REG_CTRL      = 4'h5;

    // Mode register fields
    localparam int MODE_SLEEP_BIT   = 0;
    localparam int MODE_PARTIAL_BIT = 1;
    localparam int MODE_INVERT_BIT  = 2;
    // Diagnostic byte: checksum mismatch flag
    localparam int DIAG_CSUM_BIT    = 0;
    // Control register: software reset
    localparam int CTRL_SRST_BIT    = 0;

    // Interrupt event bits
    localparam int IRQ_W            = 6;
    localparam int EV_SLEEP_IN      = 0;
    localparam int EV_SLEEP_OUT     = 1;
    localparam int EV_DISP_MODE     = 2;
    localparam int EV_INVERT        = 3;
    localparam int EV_ALL_DARK      = 4;
    localparam int EV_UNKNOWN       = 5;

    // ========================================================
    // Values after reset
    localparam logic             RST_SLEEP   = 1'b1;
    localparam logic             RST_PARTIAL = 1'b0;
    localparam logic             RST_INVERT  = 1'b0;
    localparam logic [7:0]       RST_DIAG    = 8'h00;
    localparam logic [7:0]       RST_EXPECT  = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ     = 6'h00;

endpackage : disp_cmd_pkg

// >>> rtl/cmd_decode.sv
`timescale 1ns/1ps
// ============================================================
// Command code to operation decoder
module cmd_decode
    import disp_cmd_pkg::*;
(
    input  wire logic        cmd_valid,
    input  wire logic        cmd_packet,
    input  wire logic [15:0] cmd_code,
    output disp_cmd_pkg::cmd_op_t op
);
    import disp_cmd_pkg::*;

    logic [7:0] opcode;
    logic       well_formed;

    // Wide addresses carry the opcode in the high byte
    always_comb begin
        opcode      = cmd_packet ? cmd_code[7:0] : cmd_code[15:8];
        well_formed = cmd_packet || (cmd_code[7:0] == CODE_WIDE_LOW);
        op          = OP_NONE;
        if (cmd_valid && !well_formed) begin
            op = OP_OTHER;
        end else if (cmd_valid) begin
            case (opcode)
                CODE_DIAG_RD:   op = OP_DIAG_RD;
                CODE_SLEEP_IN:  op = OP_SLEEP_IN;
                CODE_SLEEP_OUT: op = OP_SLEEP_OUT;
                CODE_PARTIAL:   op = OP_PARTIAL;
                CODE_NORMAL:    op = OP_NORMAL;
                CODE_INV_OFF:   op = OP_INV_OFF;
                CODE_INV_ON:    op = OP_INV_ON;
                CODE_ALL_DARK:  op = OP_ALL_DARK;
                default:        op = OP_OTHER;
            endcase
        end
    end

endmodule : cmd_decode

// >>> rtl/display_mode_command_decoder.sv
`timescale 1ns/1ps
module display_mode_command_decoder
    import disp_cmd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Command port from the host interface logic
    input  wire logic        cmd_valid,
    input  wire logic        cmd_packet,
    input  wire logic [15:0] cmd_code,
    input  wire logic [7:0]  csum_calc,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Mode outputs toward the display path, diagnostic response and interrupt
    output logic             sleep_mode,
    output logic             partial_mode,
    output logic             invert_mode,
    output logic             all_dark_pulse,
    output logic             resp_valid,
    output logic      [7:0]  resp_data,
    output logic             irq
);
    import disp_cmd_pkg::*;

    // ========================================================
    // State record
    typedef struct packed {
        logic             sleep;
        logic             partial;
        logic             invert;
        logic [7:0]       diag;
        logic [7:0]       expect_sum;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic             irq;
        logic [7:0]       rdata;
        logic             dark;
        logic             resp_valid;
        logic [7:0]       resp_data;
    } state_t;

    state_t  s_q;
    state_t  s_d;
    cmd_op_t op;

    // ========================================================
    // Opcode decode
    cmd_decode u_decode (
        .cmd_valid  (cmd_valid),
        .cmd_packet (cmd_packet),
        .cmd_code   (cmd_code),
        .op         (op)
    );

    // ========================================================
    // Next-state logic
    logic             srst;
    logic [IRQ_W-1:0] ev;
    logic             stat_rd;

    always_comb begin
        s_d     = s_q;
        ev      = '0;
        srst    = reg_wr && (reg_addr == REG_CTRL)
                  && reg_wdata[CTRL_SRST_BIT];
        stat_rd = reg_rd && (reg_addr == REG_IRQ_STAT);

        // Single-cycle strobes drop unless re-raised below
        s_d.dark       = 1'b0;
        s_d.resp_valid = 1'b0;

        // Command side
        case (op)
            OP_SLEEP_IN: begin
                s_d.sleep = 1'b1;
                ev[EV_SLEEP_IN] = 1'b1;
            end
            OP_SLEEP_OUT: begin
                s_d.sleep = 1'b0;
                // Diagnosis runs as sleep is left
                s_d.diag  = 8'h00;
                s_d.diag[DIAG_CSUM_BIT] =
                    (csum_calc != s_q.expect_sum);
                ev[EV_SLEEP_OUT] = 1'b1;
            end
            OP_PARTIAL: begin
                // Already partial: a harmless no-op
                if (!s_q.partial) begin
                    s_d.partial = 1'b1;
                    ev[EV_DISP_MODE] = 1'b1;
                end
            end
            OP_NORMAL: begin
                if (s_q.partial) begin
                    s_d.partial = 1'b0;
                    ev[EV_DISP_MODE] = 1'b1;
                end
            end
            OP_INV_OFF: begin
                // Only the presentation flag moves
                if (s_q.invert) begin
                    s_d.invert = 1'b0;
                    ev[EV_INVERT] = 1'b1;
                end
            end
            OP_INV_ON: begin
                if (!s_q.invert) begin
                    s_d.invert = 1'b1;
                    ev[EV_INVERT] = 1'b1;
                end
            end
            OP_ALL_DARK: begin
                s_d.dark = 1'b1;
                ev[EV_ALL_DARK] = 1'b1;
            end
            OP_DIAG_RD: begin
                s_d.resp_valid = 1'b1;
                s_d.resp_data  = s_q.diag;
            end
            OP_OTHER: begin
                ev[EV_UNKNOWN] = 1'b1;
            end
            default: begin
            end
        endcase

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                REG_EXPECT:   s_d.expect_sum = reg_wdata;
                REG_IRQ_MASK: s_d.irq_mask   = reg_wdata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        // Software reset returns mode state to defaults
        if (srst) begin
            s_d.sleep   = RST_SLEEP;
            s_d.partial = RST_PARTIAL;
            s_d.invert  = RST_INVERT;
            s_d.diag    = RST_DIAG;
            s_d.dark    = 1'b0;
        end

        // Read clears, but a same-cycle event still lands
        s_d.irq_stat = (stat_rd ? '0 : s_q.irq_stat) | ev;
        s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

        // Read data, one cycle after the strobe
        s_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                REG_MODE: begin
                    s_d.rdata[MODE_SLEEP_BIT]   = s_q.sleep;
                    s_d.rdata[MODE_PARTIAL_BIT] = s_q.partial;
                    s_d.rdata[MODE_INVERT_BIT]  = s_q.invert;
                end
                REG_DIAG:     s_d.rdata = s_q.diag;
                REG_EXPECT:   s_d.rdata = s_q.expect_sum;
                REG_IRQ_STAT: s_d.rdata = {2'b00, s_q.irq_stat};
                REG_IRQ_MASK: s_d.rdata = {2'b00, s_q.irq_mask};
                default:      s_d.rdata = 8'h00;
            endcase
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q            <= '0;
            s_q.sleep      <= RST_SLEEP;
            s_q.partial    <= RST_PARTIAL;
            s_q.invert     <= RST_INVERT;
            s_q.diag       <= RST_DIAG;
            s_q.expect_sum <= RST_EXPECT;
            s_q.irq_stat   <= RST_IRQ;
            s_q.irq_mask   <= RST_IRQ;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // Outputs, all straight from the state register.
    // No frame memory port exists here; inversion is only a
    // flag consumed by the pixel path, so stored data is safe.
    assign sleep_mode     = s_q.sleep;
    assign partial_mode   = s_q.partial;
    assign invert_mode    = s_q.invert;
    assign all_dark_pulse = s_q.dark;
    assign resp_valid     = s_q.resp_valid;
    assign resp_data      = s_q.resp_data;
    assign reg_rdata      = s_q.rdata;
    assign irq            = s_q.irq;

    // ========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    diag_csum_a: assert property (
        op == OP_SLEEP_OUT && !srst |=>
            s_q.diag[0] == ($past(csum_calc) != $past(s_q.expect_sum)))
        else $error("diag bit0 wrong after sleep exit");

    sleep_in_a: assert property (
        op == OP_SLEEP_IN |=> sleep_mode)
        else $error("sleep not entered");

    sleep_out_a: assert property (
        op == OP_SLEEP_OUT && !srst |=> !sleep_mode)
        else $error("sleep not left");

    partial_on_a: assert property (
        op == OP_PARTIAL && !srst |=> partial_mode)
        else $error("partial mode not set");

    normal_on_a: assert property (
        op == OP_NORMAL |=> !partial_mode)
        else $error("normal mode not set");

    inv_off_a: assert property (
        op == OP_INV_OFF |=> !invert_mode)
        else $error("inversion not cleared");

    inv_on_a: assert property (
        op == OP_INV_ON && !srst |=> invert_mode)
        else $error("inversion not set");

    dark_pulse_a: assert property (
        op == OP_ALL_DARK && !srst |=> all_dark_pulse
            ##1 (!all_dark_pulse || $past(op == OP_ALL_DARK)))
        else $error("all dark pulse wrong");

    partial_idle_a: assert property (
        op == OP_PARTIAL && partial_mode |=>
            !s_q.irq_stat[EV_DISP_MODE] || $past(s_q.irq_stat[EV_DISP_MODE]))
        else $error("redundant partial raised event");

    inv_iso_a: assert property (
        (op == OP_INV_OFF || op == OP_INV_ON) && !srst |=>
            $stable(sleep_mode) && $stable(partial_mode))
        else $error("inversion touched other status");

    soft_rst_a: assert property (
        srst |=> sleep_mode && !partial_mode && !invert_mode
            && s_q.diag == 8'h00)
        else $error("soft reset defaults wrong");

    irq_mask_a: assert property (
        irq |-> |(s_q.irq_stat & s_q.irq_mask))
        else $error("irq without unmasked status");

    // A status read leaves only what landed in the same cycle
    stat_clear_a: assert property (
        stat_rd |=> s_q.irq_stat == $past(ev))
        else $error("status read did not clear");

    sleep_cycle_c:   cover property (op == OP_SLEEP_IN ##[1:50]
                                     op == OP_SLEEP_OUT);
    partial_cycle_c: cover property (op == OP_PARTIAL ##[1:50]
                                     op == OP_NORMAL);
    invert_cycle_c:  cover property (op == OP_INV_ON ##[1:50]
                                     op == OP_INV_OFF);
    diag_fail_c:     cover property (s_q.diag[0] ##1 resp_valid);

endmodule : display_mode_command_decoder

// >>> test/host_cmd_model.sv
`timescale 1ns/1ps
// ============================================================
// Host processor issuing parameterless display commands
module host_cmd_model #(
    parameter int SLEEP_GAP = 6
) (
    input  wire logic        clk,
    output logic             cmd_valid,
    output logic             cmd_packet,
    output logic      [15:0] cmd_code
);
    // Idle lines start quiet; code is scrambled between commands
    initial begin
        cmd_valid  = 1'b0;
        cmd_packet = 1'b0;
        cmd_code   = 16'hffff;
    end

    // ========================================================
    // One command: a single-cycle strobe, no parameter follows
    task automatic send(input logic pkt, input logic [15:0] code);
        @(posedge clk);
        cmd_valid  <= 1'b1;
        cmd_packet <= pkt;
        cmd_code   <= code;
        @(posedge clk);
        cmd_valid  <= 1'b0;
        // Stale code must never look valid
        cmd_code   <= ~code;
        // Supplies settle after a sleep change; shortened gap
        if (code[7:0] == 8'h10 || code[7:0] == 8'h11 ||
            code[15:8] == 8'h10 || code[15:8] == 8'h11) begin
            repeat (SLEEP_GAP) @(posedge clk);
        end
    endtask : send
endmodule : host_cmd_model

// >>> test/display_mode_command_decoder_tb.sv
`timescale 1ns/1ps
module display_mode_command_decoder_tb;
    import disp_cmd_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        cmd_valid;
    logic        cmd_packet;
    logic [15:0] cmd_code;
    logic [7:0]  csum_calc;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        sleep_mode;
    logic        partial_mode;
    logic        invert_mode;
    logic        all_dark_pulse;
    logic        resp_valid;
    logic [7:0]  resp_data;
    logic        irq;
    int          n_fail;
    int          check_count;

    display_mode_command_decoder u_display_mode_command_decoder (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_packet(cmd_packet), .cmd_code(cmd_code),
        .csum_calc(csum_calc), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
        .partial_mode(partial_mode), .invert_mode(invert_mode),
        .all_dark_pulse(all_dark_pulse), .resp_valid(resp_valid),
        .resp_data(resp_data), .irq(irq)
    );

    host_cmd_model u_host_cmd_model (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_packet(cmd_packet),
        .cmd_code(cmd_code)
    );

    // ========================================================
    // Shared helpers
    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input string nm, input logic [3:0] a,
                         input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(nm, reg_rdata, exp);
    endtask : rdchk

    // Command taken, then outputs settle one edge later
    task automatic snd(input logic pkt, input logic [15:0] code);
        u_host_cmd_model.send(pkt, code);
        #1;
    endtask : snd

    task automatic modes(input logic [2:0] exp);
        chk("modes", {5'h00, invert_mode, partial_mode, sleep_mode},
            {5'h00, exp});
    endtask : modes

    // ========================================================
    // Scenarios
    task automatic t_reset();
        modes(3'b001);
        rdchk("mode reg", REG_MODE, 8'h01);
        rdchk("diag reg", REG_DIAG, 8'h00);
        rdchk("unmapped", 4'hf, 8'h00);
        wr(REG_MODE, 8'h06);
        rdchk("mode ro", REG_MODE, 8'h01);
    endtask : t_reset

    task automatic t_sleep();
        wr(REG_EXPECT, 8'ha5);
        csum_calc <= 8'ha5;
        snd(1'b1, 16'h0011);
        modes(3'b000);
        rdchk("diag match", REG_DIAG, 8'h00);
        csum_calc <= 8'ha4;
        snd(1'b0, 16'h1000);
        modes(3'b001);
        snd(1'b1, 16'h0010);
        modes(3'b001);
        snd(1'b0, 16'h1100);
        modes(3'b000);
        rdchk("diag differ", REG_DIAG, 8'h01);
        rdchk("sleep events", REG_IRQ_STAT, 8'h03);
    endtask : t_sleep

    task automatic t_modes();
        snd(1'b1, 16'h0013);
        rdchk("normal twice", REG_IRQ_STAT, 8'h00);
        snd(1'b0, 16'h1200);
        modes(3'b010);
        snd(1'b1, 16'h0012);
        modes(3'b010);
        rdchk("partial event", REG_IRQ_STAT, 8'h04);
        snd(1'b0, 16'h1300);
        modes(3'b000);
        rdchk("normal event", REG_IRQ_STAT, 8'h04);
    endtask : t_modes

    task automatic t_invert();
        wr(REG_IRQ_MASK, 8'h08);
        snd(1'b0, 16'h1200);
        snd(1'b1, 16'h0021);
        modes(3'b110);
        chk("irq set", {7'h00, irq}, 8'h01);
        rdchk("invert event", REG_IRQ_STAT, 8'h0c);
        chk("irq clear", {7'h00, irq}, 8'h00);
        snd(1'b0, 16'h2100);
        rdchk("invert twice", REG_IRQ_STAT, 8'h00);
        snd(1'b0, 16'h2000);
        modes(3'b010);
        snd(1'b1, 16'h0020);
        modes(3'b010);
        snd(1'b1, 16'h0013);
        rdchk("after clear", REG_IRQ_STAT, 8'h0c);
    endtask : t_invert

    task automatic t_dark();
        snd(1'b1, 16'h0022);
        chk("dark pkt", {7'h00, all_dark_pulse}, 8'h01);
        @(posedge clk);
        #1;
        chk("dark end", {7'h00, all_dark_pulse}, 8'h00);
        snd(1'b0, 16'h2200);
        chk("dark wide", {7'h00, all_dark_pulse}, 8'h01);
        snd(1'b0, 16'h2201);
        chk("dark bad", {7'h00, all_dark_pulse}, 8'h00);
        rdchk("dark events", REG_IRQ_STAT, 8'h30);
        snd(1'b1, 16'h000f);
        chk("diag resp", {7'h00, resp_valid}, 8'h01);
        chk("diag data", resp_data, 8'h01);
    endtask : t_dark

    task automatic t_srst();
        snd(1'b0, 16'h1200);
        snd(1'b0, 16'h2100);
        wr(REG_CTRL, 8'h01);
        modes(3'b001);
        rdchk("diag srst", REG_DIAG, 8'h00);
        rdchk("mask kept", REG_IRQ_MASK, 8'h08);
    endtask : t_srst

    // ========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        n_fail      = 0;
        check_count = 0;
        rst_n       = 1'b0;
        csum_calc   = 8'h00;
        reg_addr    = 4'h0;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_sleep();
        t_modes();
        t_invert();
        t_dark();
        t_srst();
        conclude();
    end

    // Whole run needs about a hundred and ten cycles; generous margin
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule : display_mode_command_decoder_tb
